// ---- fpc_controller.sv ----
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module fpc_controller #(
  parameter int unsigned PROG_US    = fpc_pkg::PROG_TIME_US,
  parameter int unsigned PAGE_US    = fpc_pkg::PAGE_ERASE_US,
  parameter int unsigned MASS_US    = fpc_pkg::MASS_ERASE_US,
  parameter int unsigned TOP_BYTES  = fpc_pkg::TOP_SECTOR_DEF
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       top_sector_write_option_i,
  input  wire logic                       flash_write_guard_option_i,
  input  wire logic                       code_read_guard_option_i,
  input  wire logic                       cpu_pm_wr_i,
  input  wire logic [fpc_pkg::ADDR_W-1:0] cpu_pm_addr_i,
  input  wire logic [7:0]                 cpu_pm_data_i,
  input  wire logic [fpc_pkg::ADDR_W-1:0] cpu_rd_addr_i,
  output logic      [7:0]                 cpu_rd_data_o,
  output logic                            cpu_hold_o,
  input  wire logic                       dbg_wr_i,
  input  wire logic [fpc_pkg::ADDR_W-1:0] dbg_addr_i,
  input  wire logic [7:0]                 dbg_data_i,
  input  wire logic                       dbg_mass_erase_i,
  input  wire logic                       dbg_rd_i,
  output logic      [7:0]                 dbg_rd_data_o,
  output logic                            dbg_rd_refused_o
);
  import fpc_pkg::*;

  typedef struct packed {
    fpc_lock_t                 lock;
    fpc_seq_t                  seq;
    logic                      relock;
    logic [31:0]               cnt;
    logic [ADDR_W-1:0]         addr;
    logic [7:0]                data;
    logic [15:0]               timing;
    logic [PAGE_NUM_W-1:0]     page;
    logic                      refused;
    logic                      ack;
    logic [31:0]               rdat;
    logic [7:0]                cpu_rd;
    logic [7:0]                dbg_rd;
    logic                      dbg_ref;
  } fpc_state_t;

  fpc_state_t s;
  fpc_state_t next_s;
  fpc_arr_if  arr ();

  logic wb_hit;
  logic ctrl_wr;
  logic pm_wr;
  logic [ADDR_W-1:0] pm_addr;
  logic [7:0] pm_data;
  logic mass_go;

  localparam logic [ADDR_W-1:0] TOP_BASE = ADDR_W'((1 << ADDR_W) - TOP_BYTES);

  // Protection check for a user request: op kind and target address.
  function automatic logic fpc_allowed(input fpc_op_t op, input logic [ADDR_W-1:0] a,
                                       input logic hs, input logic wp);
    if (wp) begin
      return 1'b1;
    end else if (hs) begin
      return (op != OP_MASS) && (a >= TOP_BASE);
    end else begin
      return 1'b0;
    end
  endfunction

  fpc_flash_array u_array (
    .clk_i (clk_i),
    .arr   (arr)
  );

  assign wb_ack_o         = s.ack;
  assign wb_dat_o         = s.rdat;
  assign cpu_rd_data_o    = s.cpu_rd;
  assign dbg_rd_data_o    = s.dbg_rd;
  assign dbg_rd_refused_o = s.dbg_ref;
  assign cpu_hold_o       = (s.seq != SQ_IDLE);
  assign arr.raddr        = dbg_rd_i ? dbg_addr_i : cpu_rd_addr_i;

  always_comb begin
    next_s       = s;
    next_s.ack   = 1'b0;
    arr.op_valid = 1'b0;
    arr.op       = OP_PROG;
    arr.addr     = s.addr;
    arr.wdata    = s.data;
    wb_hit       = wb_cyc_i & wb_stb_i & ~s.ack;
    ctrl_wr      = wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_CTRL);
    pm_wr        = cpu_pm_wr_i | dbg_wr_i;
    pm_addr      = dbg_wr_i ? dbg_addr_i : cpu_pm_addr_i;
    pm_data      = dbg_wr_i ? dbg_data_i : cpu_pm_data_i;
    mass_go      = 1'b0;

    // Register reads and writes.
    if (wb_hit) begin
      next_s.ack  = 1'b1;
      next_s.rdat = 32'h0000_0000;
      if (wb_we_i) begin
        if (wb_adr_i == OFS_TIMING) begin
          if (wb_sel_i[0]) next_s.timing[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_s.timing[15:8] = wb_dat_i[15:8];
        end
        if (wb_adr_i == OFS_PAGE && wb_sel_i[0]) next_s.page = wb_dat_i[PAGE_NUM_W-1:0];
        if (wb_adr_i == OFS_STATUS && wb_sel_i[0] && wb_dat_i[ST_REFUSED_BIT]) next_s.refused = 1'b0;
      end else begin
        case (wb_adr_i)
          OFS_TIMING: next_s.rdat = {16'h0000, s.timing};
          OFS_PAGE:   next_s.rdat = 32'(s.page);
          OFS_STATUS: begin
            next_s.rdat[ST_LOCK_LSB +: 2] = s.lock;
            next_s.rdat[ST_BUSY_BIT]      = (s.seq != SQ_IDLE);
            next_s.rdat[ST_REFUSED_BIT]   = s.refused;
            next_s.rdat[ST_HS_BIT]        = top_sector_write_option_i;
            next_s.rdat[ST_WP_BIT]        = flash_write_guard_option_i;
            next_s.rdat[ST_RP_BIT]        = code_read_guard_option_i;
          end
          default:    next_s.rdat = 32'h0000_0000;
        endcase
      end
    end

    // Sequencer and lock.
    case (s.seq)
      SQ_IDLE: begin
        if (dbg_mass_erase_i) begin
          mass_go       = 1'b1;
          next_s.seq    = SQ_MERASE;
          next_s.relock = 1'b0;
          next_s.cnt    = fpc_cycles(s.timing, MASS_US);
        end
        if (ctrl_wr) begin
          case (s.lock)
            LK_OPEN: begin
              next_s.lock = LK_LOCKED;
              if (!mass_go && (wb_dat_i[7:0] == CMD_PAGE_ERASE || wb_dat_i[7:0] == CMD_MASS_ERASE)) begin
                next_s.addr = {s.page, PAGE_W'(0)};
                if (fpc_allowed((wb_dat_i[7:0] == CMD_MASS_ERASE) ? OP_MASS : OP_PAGE, {s.page, PAGE_W'(0)},
                                top_sector_write_option_i, flash_write_guard_option_i)) begin
                  next_s.lock   = LK_OPEN;
                  next_s.relock = 1'b1;
                  next_s.seq    = (wb_dat_i[7:0] == CMD_MASS_ERASE) ? SQ_MERASE : SQ_PERASE;
                  next_s.cnt    = fpc_cycles(s.timing, (wb_dat_i[7:0] == CMD_MASS_ERASE) ? MASS_US : PAGE_US);
                end else begin
                  next_s.refused = 1'b1;
                end
              end
            end
            LK_HALF: begin
              if (wb_dat_i[7:0] == UNLOCK_SECOND) next_s.lock = LK_OPEN;
              else if (wb_dat_i[7:0] == UNLOCK_FIRST) next_s.lock = LK_HALF;
              else next_s.lock = LK_LOCKED;
            end
            default: next_s.lock = (wb_dat_i[7:0] == UNLOCK_FIRST) ? LK_HALF : LK_LOCKED;
          endcase
        end else if (pm_wr && !mass_go && s.lock == LK_OPEN) begin
          if (fpc_allowed(OP_PROG, pm_addr, top_sector_write_option_i, flash_write_guard_option_i)) begin
            next_s.seq    = SQ_PROG;
            next_s.relock = 1'b0;
            next_s.addr   = pm_addr;
            next_s.data   = pm_data;
            next_s.cnt    = fpc_cycles(s.timing, PROG_US);
          end else begin
            next_s.refused = 1'b1;
          end
        end
      end
      SQ_PROG, SQ_PERASE, SQ_MERASE: begin
        if (s.cnt <= 32'd1) begin
          arr.op_valid = 1'b1;
          arr.op       = (s.seq == SQ_PROG) ? OP_PROG : ((s.seq == SQ_PERASE) ? OP_PAGE : OP_MASS);
          next_s.seq   = SQ_IDLE;
          next_s.cnt   = 32'd0;
          if (s.relock) next_s.lock = LK_LOCKED;
          next_s.relock = 1'b0;
        end else begin
          next_s.cnt = s.cnt - 32'd1;
        end
      end
      default: next_s.seq = SQ_IDLE;
    endcase

    // Flash read ports.
    if (dbg_rd_i) begin
      next_s.dbg_rd  = code_read_guard_option_i ? 8'h00 : arr.rdata;
      next_s.dbg_ref = code_read_guard_option_i;
    end else begin
      next_s.cpu_rd  = arr.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.lock   <= LK_LOCKED;
      s.seq    <= SQ_IDLE;
      s.timing <= TIMING_RESET;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence ctrl_write_s(logic [7:0] v);
    ctrl_wr && s.seq == SQ_IDLE && !dbg_mass_erase_i && wb_dat_i[7:0] == v;
  endsequence

  sequence prog_start_s;
    s.seq == SQ_IDLE ##1 s.seq == SQ_PROG;
  endsequence

  sequence erase_start_s;
    s.seq == SQ_IDLE ##1 s.seq == SQ_PERASE;
  endsequence

  sequence erase_done_s;
    (s.seq == SQ_PERASE || s.seq == SQ_MERASE) && s.relock && s.cnt <= 32'd1;
  endsequence

  reset_locks_a: assert property (disable iff (1'b0) rst_i |=> s.lock == LK_LOCKED && s.seq == SQ_IDLE)
    else $error("controller not locked after reset");
  locked_no_op_a: assert property (arr.op_valid && arr.op != OP_MASS |-> s.lock == LK_OPEN)
    else $error("flash changed while locked");
  locked_prog_a: assert property (s.lock != LK_OPEN && s.seq == SQ_IDLE && pm_wr |=> s.seq != SQ_PROG)
    else $error("program started while locked");

  first_unlock_a: assert property (s.lock == LK_LOCKED ##0 ctrl_write_s(UNLOCK_FIRST) |=> s.lock == LK_HALF)
    else $error("first unlock value not recorded");
  unlock_pair_a: assert property (s.lock == LK_HALF ##0 ctrl_write_s(UNLOCK_SECOND) |=> s.lock == LK_OPEN)
    else $error("unlock pair did not open the controller");
  bad_second_a: assert property (s.lock == LK_HALF && ctrl_wr && s.seq == SQ_IDLE &&
                                 wb_dat_i[7:0] != UNLOCK_SECOND |=> s.lock != LK_OPEN)
    else $error("wrong second unlock value opened the controller");
  relock_write_a: assert property (s.lock == LK_OPEN && ctrl_wr && s.seq == SQ_IDLE && !dbg_mass_erase_i &&
                                   wb_dat_i[7:0] != CMD_PAGE_ERASE && wb_dat_i[7:0] != CMD_MASS_ERASE
                                   |=> s.lock == LK_LOCKED)
    else $error("control write did not relock");
  erase_first_a: assert property (erase_done_s |-> s.lock == LK_OPEN && arr.op_valid ##1
                                  s.lock == LK_LOCKED && s.seq == SQ_IDLE)
    else $error("erase did not finish before relock");

  prog_hold_a: assert property (prog_start_s |-> cpu_hold_o && !$past(cpu_hold_o))
    else $error("processor not held during program");
  prog_len_a: assert property (prog_start_s |-> s.cnt == fpc_cycles(s.timing, PROG_US))
    else $error("program time not derived from timing value");
  erase_len_a: assert property (erase_start_s |-> s.cnt == fpc_cycles(s.timing, PAGE_US))
    else $error("erase time not derived from timing value");

  no_guard_a: assert property (!top_sector_write_option_i && !flash_write_guard_option_i &&
                               s.seq == SQ_IDLE && pm_wr && s.lock == LK_OPEN && !ctrl_wr && !dbg_mass_erase_i
                               |=> s.seq != SQ_PROG && s.refused)
    else $error("program accepted with both guard options clear");
  dbg_mass_a: assert property (s.seq == SQ_IDLE && dbg_mass_erase_i |=> s.seq == SQ_MERASE && !s.relock)
    else $error("debugger mass erase not started");
  top_only_a: assert property (top_sector_write_option_i && !flash_write_guard_option_i &&
                               s.lock == LK_OPEN && s.seq == SQ_IDLE && pm_wr && !ctrl_wr &&
                               !dbg_mass_erase_i && pm_addr < TOP_BASE
                               |=> s.seq == SQ_IDLE && s.refused)
    else $error("program outside the top sector accepted");
  guard_all_a: assert property (flash_write_guard_option_i && s.lock == LK_OPEN && s.seq == SQ_IDLE &&
                                pm_wr && !ctrl_wr && !dbg_mass_erase_i |=> s.seq == SQ_PROG)
    else $error("program refused with the write guard option set");
  read_guard_a: assert property (dbg_rd_i && code_read_guard_option_i |=>
                                 dbg_rd_refused_o && dbg_rd_data_o == 8'h00)
    else $error("debugger read not refused");
  refuse_idle_a: assert property ($rose(s.refused) |-> s.seq == SQ_IDLE && !arr.op_valid)
    else $error("refused request reached the flash");

endmodule // fpc_controller
`default_nettype wire

// ---- fpc_pkg.sv ----
package fpc_pkg;

  // Flash geometry.
  localparam int unsigned ADDR_W          = 14;
  localparam int unsigned PAGE_W          = 9;
  localparam int unsigned PAGE_NUM_W      = ADDR_W - PAGE_W;
  localparam int unsigned TOP_SECTOR_DEF  = 4096;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;

  // Register byte offsets.
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_TIMING      = 8'h04;
  localparam logic [7:0]  OFS_PAGE        = 8'h08;
  localparam logic [7:0]  OFS_STATUS      = 8'h0C;

  // Status field positions.
  localparam int unsigned ST_LOCK_LSB     = 0;
  localparam int unsigned ST_BUSY_BIT     = 2;
  localparam int unsigned ST_REFUSED_BIT  = 3;
  localparam int unsigned ST_HS_BIT       = 4;
  localparam int unsigned ST_WP_BIT       = 5;
  localparam int unsigned ST_RP_BIT       = 6;

  // Control register codes.
  localparam logic [7:0]  UNLOCK_FIRST    = 8'h73;
  localparam logic [7:0]  UNLOCK_SECOND   = 8'h8C;
  localparam logic [7:0]  CMD_PAGE_ERASE  = 8'hA5;
  localparam logic [7:0]  CMD_MASS_ERASE  = 8'h5A;

  // Reset values.
  localparam logic [15:0] TIMING_RESET    = 16'h0000;

  // Operation times in microseconds.
  localparam int unsigned PROG_TIME_US    = 40;
  localparam int unsigned PAGE_ERASE_US   = 10000;
  localparam int unsigned MASS_ERASE_US   = 20000;

  typedef enum logic [1:0] {LK_LOCKED = 2'b00, LK_HALF = 2'b01, LK_OPEN = 2'b11} fpc_lock_t;
  typedef enum logic [1:0] {SQ_IDLE = 2'b00, SQ_PROG = 2'b01, SQ_PERASE = 2'b11, SQ_MERASE = 2'b10} fpc_seq_t;
  typedef enum logic [1:0] {OP_PROG = 2'b00, OP_PAGE = 2'b01, OP_MASS = 2'b10} fpc_op_t;

  // Cycles for a time in microseconds at a clock given in kHz, rounded up, never below one.
  function automatic logic [31:0] fpc_cycles(input logic [15:0] khz, input int unsigned us);
    logic [31:0] prod;
    prod = (32'(khz) * 32'(us) + 32'd999) / 32'd1000;
    return (prod == 32'd0) ? 32'd1 : prod;
  endfunction

endpackage

// ---- fpc_arr_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fpc_arr_if;
  import fpc_pkg::*;
  logic              op_valid;
  fpc_op_t           op;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic [ADDR_W-1:0] raddr;
  logic [7:0]        rdata;
  modport ctrl  (output op_valid, op, addr, wdata, raddr, input rdata);
  modport array (input op_valid, op, addr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ---- fpc_flash_array.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_array (
  input  wire logic   clk_i,
  fpc_arr_if.array    arr
);
  import fpc_pkg::*;

  logic [7:0] mem [0:(1 << ADDR_W) - 1];

  assign arr.rdata = mem[arr.raddr];

  always_ff @(posedge clk_i) begin
    if (arr.op_valid) begin
      case (arr.op)
        OP_PROG: mem[arr.addr] <= mem[arr.addr] & arr.wdata;
        OP_PAGE: begin
          for (int i = 0; i < (1 << PAGE_W); i++) begin
            mem[{arr.addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= ERASED_BYTE;
          end
        end
        OP_MASS: begin
          for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem[i] <= ERASED_BYTE;
          end
        end
        default: ;
      endcase
    end
  end

endmodule // fpc_flash_array
`default_nettype wire

// ---- fpc_soft_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpc_soft_model (
  input  wire logic                       clk_i,
  input  wire logic                       hold_i,
  output var  logic                       pm_wr_o,
  output var  logic [fpc_pkg::ADDR_W-1:0] pm_addr_o,
  output var  logic [7:0]                 pm_data_o
);
  import fpc_pkg::*;
  initial begin
    pm_wr_o = 1'b0;
    pm_addr_o = '0;
    pm_data_o = 8'h00;
  end
  // Issues one program memory load, never while the processor is held, then scrambles the released lines.
  task automatic prog(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    while (hold_i === 1'b1) @(posedge clk_i);
    pm_wr_o <= 1'b1;
    pm_addr_o <= a;
    pm_data_o <= d;
    @(posedge clk_i);
    pm_wr_o <= 1'b0;
    pm_addr_o <= ~a;
    pm_data_o <= ~d;
  endtask
endmodule // fpc_soft_model
`default_nettype wire

// ---- flash_program_erase_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_controller_tb;
  import fpc_pkg::*;
  typedef struct packed {logic hs; logic wp; logic [13:0] addr; logic [7:0] data; logic [7:0] exp;} fpc_row_t;
  logic              clk_i, rst_i, cyc, stb, we, ack, hs, wp, rp, pm_wr, hold, dbg_wr, dbg_me, dbg_rd, dbg_ref;
  logic [7:0]        adr, pm_data, rd_data, dbg_data, dbg_q, b;
  logic [3:0]        sel;
  logic [31:0]       dat_w, dat_r, q;
  logic [ADDR_W-1:0] pm_addr, rd_addr, dbg_addr;
  int                num_errors, samples_checked, n;
  fpc_row_t          rows [7];

  // Short operation times keep the run brief while the timing value holds the true clock in kHz.
  fpc_controller #(.PROG_US(1), .PAGE_US(10), .MASS_US(20)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .top_sector_write_option_i(hs),
    .flash_write_guard_option_i(wp), .code_read_guard_option_i(rp), .cpu_pm_wr_i(pm_wr), .cpu_pm_addr_i(pm_addr),
    .cpu_pm_data_i(pm_data), .cpu_rd_addr_i(rd_addr), .cpu_rd_data_o(rd_data), .cpu_hold_o(hold),
    .dbg_wr_i(dbg_wr), .dbg_addr_i(dbg_addr), .dbg_data_i(dbg_data), .dbg_mass_erase_i(dbg_me),
    .dbg_rd_i(dbg_rd), .dbg_rd_data_o(dbg_q), .dbg_rd_refused_o(dbg_ref));
  fpc_soft_model cpu (.clk_i(clk_i), .hold_i(hold), .pm_wr_o(pm_wr), .pm_addr_o(pm_addr), .pm_data_o(pm_data));

  always #50 clk_i = ~clk_i;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hF;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 50) check("bus ack", 32'h0, 32'h1);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] r);
    @(posedge clk_i);
    rd_addr <= a;
    repeat (2) @(posedge clk_i);
    r = rd_data;
  endtask
  task automatic dbg_op(input logic w, input logic me, input logic r, input logic [13:0] a, input logic [7:0] d);
    @(posedge clk_i);
    dbg_wr <= w;
    dbg_me <= me;
    dbg_rd <= r;
    dbg_addr <= a;
    dbg_data <= d;
    @(posedge clk_i);
    dbg_wr <= 1'b0;
    dbg_me <= 1'b0;
    dbg_rd <= 1'b0;
    dbg_data <= ~d;
  endtask
  task automatic hold_cnt(output int c);
    c = 0;
    @(posedge clk_i);
    while (hold === 1'b1 && c < 1000) begin
      c++;
      @(posedge clk_i);
    end
  endtask
  task automatic unlock();
    wb(1'b1, OFS_CTRL, 32'h73, q);
    wb(1'b1, OFS_CTRL, 32'h8C, q);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    {clk_i, cyc, stb, we, dbg_wr, dbg_me, dbg_rd, hs, rp} = '0;
    {adr, dbg_data, dat_w, rd_addr, dbg_addr} = '0;
    {rst_i, wp, sel} = {1'b1, 1'b1, 4'hF};
    rows = '{'{1'b0, 1'b0, 14'h0005, 8'h00, 8'hFF}, '{1'b1, 1'b0, 14'h0005, 8'h00, 8'hFF},
             '{1'b1, 1'b0, 14'h3FFF, 8'h12, 8'h12}, '{1'b1, 1'b0, 14'h3000, 8'h34, 8'h34},
             '{1'b1, 1'b0, 14'h2FFF, 8'h56, 8'hFF}, '{1'b0, 1'b1, 14'h0005, 8'h3C, 8'h3C},
             '{1'b1, 1'b1, 14'h0005, 8'hC3, 8'hC3}};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check("status after reset", q, 32'h20);
    wb(1'b1, OFS_TIMING, 32'h2710, q);
    wb(1'b0, OFS_TIMING, 32'h0, q);
    check("timing value", q, 32'h2710);
    wb(1'b0, 8'h10, 32'h0, q);
    check("unmapped read", q, 32'h0);
    dbg_op(1'b0, 1'b1, 1'b0, 14'h0, 8'h00);
    hold_cnt(n);
    check("debug mass erase cycles", 32'(n), 32'd200);
    cpu.prog(14'h0005, 8'h00);
    hold_cnt(n);
    rd(14'h0005, b);
    check("locked program", {n[23:0], b}, 32'hFF);
    $display("reset and timing test done");
    wb(1'b1, OFS_CTRL, 32'h73, q);
    wb(1'b1, OFS_CTRL, 32'h12, q);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check("wrong second write", q & 32'h3, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h73, q);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check("first unlock write", q & 32'h3, 32'h1);
    wb(1'b1, OFS_CTRL, 32'h8C, q);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check("unlocked", q & 32'h3, 32'h3);
    cpu.prog(14'h0005, 8'hA5);
    hold_cnt(n);
    check("program hold cycles", 32'(n), 32'd10);
    cpu.prog(14'h0005, 8'h5A);
    hold_cnt(n);
    rd(14'h0005, b);
    check("program clears only", {24'h0, b}, 32'h00);
    dbg_op(1'b1, 1'b0, 1'b0, 14'h0006, 8'h0F);
    hold_cnt(n);
    rd(14'h0006, b);
    check("debugger program", {n[23:0], b}, 32'hA0F);
    wb(1'b1, OFS_CTRL, 32'h00, q);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check("relock on write", q & 32'h3, 32'h0);
    $display("unlock and program test done");
    wb(1'b1, OFS_PAGE, 32'h0, q);
    unlock();
    wb(1'b1, OFS_CTRL, {24'h0, CMD_PAGE_ERASE}, q);
    check("erase starts busy", {31'h0, hold}, 32'h1);
    hold_cnt(n);
    rd(14'h0005, b);
    check("page erase result", {n[23:0], b}, 32'h63FF);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check("locked after erase", q & 32'h3, 32'h0);
    $display("page erase test done");
    rp <= 1'b1;
    dbg_op(1'b0, 1'b0, 1'b1, 14'h0006, 8'h00);
    @(posedge clk_i);
    check("guarded debug read", {23'h0, dbg_ref, dbg_q}, 32'h100);
    rp <= 1'b0;
    dbg_op(1'b0, 1'b0, 1'b1, 14'h0006, 8'h00);
    @(posedge clk_i);
    check("open debug read", {23'h0, dbg_ref, dbg_q}, 32'h0FF);
    $display("debug read test done");
    foreach (rows[i]) begin
      dbg_op(1'b0, 1'b1, 1'b0, 14'h0, 8'h00);
      hold_cnt(n);
      hs <= rows[i].hs;
      wp <= rows[i].wp;
      unlock();
      cpu.prog(rows[i].addr, rows[i].data);
      hold_cnt(n);
      rd(rows[i].addr, b);
      check("guarded program", {24'h0, b}, {24'h0, rows[i].exp});
      wb(1'b0, OFS_STATUS, 32'h0, q);
      check("refused flag", {31'h0, q[ST_REFUSED_BIT]}, {31'h0, rows[i].exp != rows[i].data});
      wb(1'b1, OFS_STATUS, 32'h8, q);
      wb(1'b1, OFS_CTRL, 32'h00, q);
    end
    $display("protection table test done");
    {hs, wp} <= 2'b10;
    unlock();
    wb(1'b1, OFS_CTRL, {24'h0, CMD_MASS_ERASE}, q);
    hold_cnt(n);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check("user mass erase refused", {n[23:0], q[7:0] & 8'h0B}, 32'h08);
    rd(14'h0005, b);
    check("flash kept after refusal", {24'h0, b}, 32'hC3);
    wp <= 1'b1;
    unlock();
    wb(1'b1, OFS_CTRL, {24'h0, CMD_MASS_ERASE}, q);
    hold_cnt(n);
    rd(14'h0005, b);
    check("user mass erase", {n[23:0], b}, 32'hC7FF);
    $display("mass erase test done");
    unlock();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_STATUS, 32'h0, q);
    check("locked after mid-run reset", q & 32'h7, 32'h0);
    wb(1'b0, OFS_TIMING, 32'h0, q);
    check("timing after mid-run reset", q, {16'h0, TIMING_RESET});
    $display("mid-run reset test done");
    finish_test();
  end
endmodule // flash_program_erase_controller_tb
`default_nettype wire
